/* dv/cpu_interrupt_sequencer_bench.sv */
// Purpose: self-checking bench of the cpu interrupt sequencer
// Assumes: core and peripherals are played by the bench, memory by the model
// Notes: expected results queue up; a monitor compares them as they appear
`timescale 1ns/1ps
`default_nettype none

module cpu_interrupt_sequencer_bench
  import cpu_irq_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic irq_pin = 1'b0;
  logic rd_pend = 1'b0;
  logic [3:0] req = 4'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [6:0] periph_event = 7'h00;
  logic [6:0] ev;
  logic [7:0] reg_rdata, mem_rdata, condition_code_register, queue_byte;
  logic irq, busy, frame_load, queue_valid;
  cpu_frame_t cpu_now = '0;
  cpu_frame_t frame_out, saved;
  mem_req_t mem_req;
  int error_cnt = 0;
  int comparisons = 0;
  int seed = 6417;
  int n_hw, n_rt, n_sw, n_db;
  logic [7:0] rd_q [$];
  logic [7:0] byte_q [$];
  cpu_frame_t frame_q [$];

  always #50 clk = ~clk;

  cpu_interrupt_sequencer cpu_interrupt_sequencer_inst (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .periph_event(periph_event), .irq_pin(irq_pin), .instr_boundary(req[0]),
    .swi_exec(req[1]), .debug_swi(req[2]), .rti_exec(req[3]), .cpu_now(cpu_now),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .condition_code_register(condition_code_register), .irq(irq), .busy(busy),
    .frame_load(frame_load), .frame_out(frame_out), .queue_valid(queue_valid),
    .queue_byte(queue_byte)
  );

  stack_memory_model stack_memory_model_inst (
    .clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata)
  );

  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // an unexpected pulse meets an unknown note and so counts as a mismatch
  always @(posedge clk) begin
    if (rd_pend) check(reg_rdata, rd_q.size() ? rd_q.pop_front() : 8'hxx);
    if (frame_load) check(frame_out, frame_q.size() ? frame_q.pop_front() : 'x);
    if (queue_valid) check(queue_byte, byte_q.size() ? byte_q.pop_front() : 8'hxx);
    rd_pend <= reg_re;
  end

  // ----------------------------------------------------------------
  // register bus and core requests
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    rd_q.push_back(e);
    @(posedge clk);
    reg_re <= 1'b0;
  endtask

  // k: 0 boundary, 1 software, 2 debug, 3 return
  task automatic seq(input int k, input logic [15:0] vec, input logic [7:0] ccr_exp,
                     output int n);
    cpu_frame_t f;
    logic [15:0] tgt;
    logic [7:0] stk [5];
    f.pc = 16'($random(seed));
    f.x = 8'($random(seed));
    f.a = 8'($random(seed));
    f.sp = 16'h0180 + 16'($random(seed) & 'h3f);
    tgt = 16'h2000 + 16'($random(seed) & 'hfff);
    if (k != 3) begin
      stack_memory_model_inst.mem[vec] = tgt[15:8];
      stack_memory_model_inst.mem[vec + 16'h0001] = tgt[7:0];
      for (int i = 0; i < 3; i++) begin
        stack_memory_model_inst.mem[tgt + 16'(i)] = 8'($random(seed));
        byte_q.push_back(stack_memory_model_inst.mem[tgt + 16'(i)]);
      end
      frame_q.push_back({tgt, f.x, f.a, f.sp - FRAME_BYTES});
      saved = f;
    end else begin
      f.sp = saved.sp - FRAME_BYTES;
      frame_q.push_back(saved);
    end
    @(posedge clk);
    cpu_now <= f;
    req[k] <= 1'b1;
    @(posedge clk);
    req[k] <= 1'b0;
    n = 1;
    while (frame_load !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (frame_load !== 1'b1) begin
      error_cnt++;
      finish_test();
    end
    check(condition_code_register, (k == 3) ? ccr_exp : (ccr_exp | (8'h01 << CCR_I_BIT)));
    stk = '{f.pc[7:0], f.pc[15:8], f.x, f.a, ccr_exp};
    if (k != 3) begin
      for (int i = 0; i < 5; i++) begin
        check(stack_memory_model_inst.mem[f.sp - 16'(i)], stk[i]);
      end
    end
    rd(ADDR_CCR, (k == 3) ? ccr_exp : (ccr_exp | (8'h01 << CCR_I_BIT)));
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rd(ADDR_CCR, CCR_RESET);
    rd(ADDR_ENABLE, ENABLE_RESET);
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_SEQ, 8'h00);
    rd(4'h7, 8'h00);
    // pin detection, edge-only then level
    @(posedge clk);
    irq_pin <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ADDR_STATUS, 8'h01);
    wr(ADDR_STATUS, 8'h01);
    rd(ADDR_STATUS, 8'h00);
    @(posedge clk);
    irq_pin <= 1'b0;
    wr(ADDR_CTRL, 8'h01);
    rd(ADDR_CTRL, 8'h01);
    @(posedge clk);
    irq_pin <= 1'b1;
    repeat (3) @(posedge clk);
    wr(ADDR_STATUS, 8'h01);
    rd(ADDR_STATUS, 8'h01);
    @(posedge clk);
    irq_pin <= 1'b0;
    repeat (3) @(posedge clk);
    wr(ADDR_STATUS, 8'h01);
    rd(ADDR_STATUS, 8'h00);
    // peripheral events, local enables
    ev = 7'($random(seed)) | 7'h01;
    @(posedge clk);
    periph_event <= ev;
    @(posedge clk);
    periph_event <= 7'h00;
    rd(ADDR_STATUS, {ev, 1'b0});
    @(negedge clk);
    check(irq, 1'b0);
    wr(ADDR_ENABLE, {ev, 1'b0});
    @(negedge clk);
    check(irq, 1'b1);
    wr(ADDR_STATUS, 8'hff);
    rd(ADDR_STATUS, 8'h00);
    @(negedge clk);
    check(irq, 1'b0);
    // two sources pending, mask still set from reset
    @(posedge clk);
    periph_event <= 7'h12;
    @(posedge clk);
    periph_event <= 7'h00;
    wr(ADDR_ENABLE, 8'hff);
    @(posedge clk);
    req[0] <= 1'b1;
    repeat (3) @(posedge clk);
    req[0] <= 1'b0;
    @(negedge clk);
    check(busy, 1'b0);
    wr(ADDR_CCR, 8'h00);
    repeat (5) begin
      @(negedge clk);
      check(busy, 1'b0);
    end
    seq(0, VEC_SRC_TOP - 16'h000a, 8'h00, n_hw);
    seq(3, 16'h0000, 8'h00, n_rt);
    seq(1, VEC_SWI_ADDR, 8'h00, n_sw);
    seq(2, VEC_SWI_ADDR, 8'h08, n_db);
    check(n_sw, n_hw);
    check(n_db, n_hw);
    repeat (4) @(posedge clk);
    check(frame_q.size() + byte_q.size() + rd_q.size(), 0);
    finish_test();
  end
endmodule // cpu_interrupt_sequencer_bench

`default_nettype wire

/* dv/stack_memory_model.sv */
// Purpose: stack and vector memory on the far side of the sequencer
// Assumes: reads answer in the cycle after the request, writes land at the edge
// Notes: outside a read answer the data lines toggle, never hold the old byte
`timescale 1ns/1ps
`default_nettype none

module stack_memory_model
  import cpu_irq_pkg::*;
(
  input wire logic clk, // core clock
  input wire mem_req_t mem_req, // request from the sequencer
  output logic [7:0] mem_rdata // read data, cycle after re
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] mem [0:65535];

  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h00;
    end
  end

  always @(posedge clk) begin
    if (mem_req.we) begin
      mem[mem_req.addr] <= mem_req.wdata;
    end
    // stale data would hide a missed read strobe
    if (mem_req.re) begin
      mem_rdata <= mem[mem_req.addr];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // stack_memory_model

`default_nettype wire

/* rtl/cpu_interrupt_sequencer.sv */
// Purpose: interrupt flags, request qualification, stacking, vector fetch and return
// Assumes: core reports instruction boundaries; memory answers a read in the next cycle
// Notes: index high register is never touched here
//
// The address map and the plain strobed port were decided locally.

`timescale 1ns/1ps
`default_nettype none

module cpu_interrupt_sequencer
  import cpu_irq_pkg::*;
(
  input wire logic clk, // 10 MHz core clock
  input wire logic reset, // synchronous, active high
  input wire logic [3:0] reg_addr, // register index
  input wire logic [7:0] reg_wdata, // register write data
  input wire logic reg_we, // write strobe
  input wire logic reg_re, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  input wire logic [6:0] periph_event, // peripheral event pulses, flags 7..1
  input wire logic irq_pin, // external pin, high is asserted
  input wire logic instr_boundary, // current instruction completes now
  input wire logic swi_exec, // software interrupt instruction decoded
  input wire logic debug_swi, // debug logic asks for software interrupt
  input wire logic rti_exec, // return instruction decoded
  input wire cpu_frame_t cpu_now, // next pc, x, a, sp of the core
  output mem_req_t mem_req, // stack and vector memory request
  input wire logic [7:0] mem_rdata, // read data, cycle after request
  output logic [7:0] condition_code_register, // condition_code_register
  output logic irq, // some enabled flag is set
  output logic busy, // sequence in progress
  output logic frame_load, // pulse: core loads frame_out
  output cpu_frame_t frame_out, // registers for the core
  output logic queue_valid, // pulse: queue_byte is valid
  output logic [7:0] queue_byte // instruction queue byte
);

  seq_regs_t s_q, s_d;
  logic [7:0] pend;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] top_source(input logic [7:0] p);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (p[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [15:0] vec_addr(input logic [3:0] sel);
    if (sel == SWI_SEL) begin
      return VEC_SWI_ADDR;
    end
    return VEC_SRC_TOP - {11'h000, sel, 1'b0};
  endfunction

  function automatic logic [15:0] shift_addr(input logic [15:0] base, input logic [15:0] d);
    return base + d;
  endfunction

  assign pend = s_q.flags & s_q.enable;
  assign irq = |pend;
  assign condition_code_register = s_q.condition_code_register;
  assign busy = (s_q.st != S_IDLE);
  assign reg_rdata = s_q.rdata;
  assign frame_load = s_q.frame_load;
  assign frame_out = s_q.frame_out;
  assign queue_valid = s_q.queue_valid;
  assign queue_byte = s_q.queue_byte;

  // ----------------------------------------------------------------
  // memory request decode
  // ----------------------------------------------------------------
  always_comb begin
    mem_req = '0;
    case (s_q.st)
      S_P_PCL: begin
        mem_req = '{s_q.snap.sp, s_q.snap.pc[7:0], 1'b1, 1'b0};
      end
      S_P_PCH: begin
        mem_req = '{shift_addr(s_q.snap.sp, 16'hffff), s_q.snap.pc[15:8], 1'b1, 1'b0};
      end
      S_P_X: begin
        mem_req = '{shift_addr(s_q.snap.sp, 16'hfffe), s_q.snap.x, 1'b1, 1'b0};
      end
      S_P_A: begin
        mem_req = '{shift_addr(s_q.snap.sp, 16'hfffd), s_q.snap.a, 1'b1, 1'b0};
      end
      S_P_CCR: begin
        mem_req = '{shift_addr(s_q.snap.sp, 16'hfffc), s_q.condition_code_register, 1'b1, 1'b0};
      end
      S_V_HI: begin
        mem_req = '{vec_addr(s_q.vsel), 8'h00, 1'b0, 1'b1};
      end
      S_V_LO: begin
        mem_req = '{shift_addr(vec_addr(s_q.vsel), 16'h0001), 8'h00, 1'b0, 1'b1};
      end
      S_Q0: begin
        mem_req = '{s_q.target, 8'h00, 1'b0, 1'b1};
      end
      S_Q1: begin
        mem_req = '{shift_addr(s_q.target, 16'h0001), 8'h00, 1'b0, 1'b1};
      end
      S_Q2: begin
        mem_req = '{shift_addr(s_q.target, 16'h0002), 8'h00, 1'b0, 1'b1};
      end
      S_U_CCR: begin
        mem_req = '{shift_addr(s_q.snap.sp, 16'h0001), 8'h00, 1'b0, 1'b1};
      end
      S_U_A: begin
        mem_req = '{shift_addr(s_q.snap.sp, 16'h0002), 8'h00, 1'b0, 1'b1};
      end
      S_U_X: begin
        mem_req = '{shift_addr(s_q.snap.sp, 16'h0003), 8'h00, 1'b0, 1'b1};
      end
      S_U_PCH: begin
        mem_req = '{shift_addr(s_q.snap.sp, 16'h0004), 8'h00, 1'b0, 1'b1};
      end
      S_U_PCL: begin
        mem_req = '{shift_addr(s_q.snap.sp, 16'h0005), 8'h00, 1'b0, 1'b1};
      end
      default: begin
        mem_req = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] clr;
    logic [7:0] hold;
    logic pin_edge;
    clr = 8'h00;
    hold = 8'h00;
    pin_edge = 1'b0;
    s_d = s_q;
    s_d.frame_load = 1'b0;
    s_d.queue_valid = 1'b0;
    s_d.rdata = 8'h00;
    if (reg_we) begin
      if (reg_addr == ADDR_STATUS) begin
        clr = reg_wdata;
      end else if (reg_addr == ADDR_ENABLE) begin
        s_d.enable = reg_wdata;
      end else if (reg_addr == ADDR_CTRL) begin
        s_d.lvl_sel = reg_wdata[CTRL_LVL_BIT];
      end else if (reg_addr == ADDR_CCR) begin
        s_d.condition_code_register = reg_wdata;
      end
    end
    if (reg_re) begin
      if (reg_addr == ADDR_STATUS) begin
        s_d.rdata = s_q.flags;
      end else if (reg_addr == ADDR_ENABLE) begin
        s_d.rdata = s_q.enable;
      end else if (reg_addr == ADDR_CTRL) begin
        s_d.rdata = {7'h00, s_q.lvl_sel};
      end else if (reg_addr == ADDR_CCR) begin
        s_d.rdata = s_q.condition_code_register;
      end else if (reg_addr == ADDR_SEQ) begin
        s_d.rdata = {2'b00, busy, s_q.st};
      end
    end
    // new events win over a clear in the same cycle
    s_d.pin_q = irq_pin;
    pin_edge = irq_pin & ~s_q.pin_q;
    hold[PIN_FLAG_BIT] = s_q.lvl_sel & irq_pin;
    s_d.flags = {periph_event, pin_edge} | (s_q.flags & ~(clr & ~hold));
    case (s_q.st)
      S_IDLE: begin
        if (swi_exec || debug_swi) begin
          s_d.vsel = SWI_SEL;
          s_d.snap = cpu_now;
          s_d.st = S_P_PCL;
        end else if (rti_exec) begin
          s_d.snap = cpu_now;
          s_d.st = S_U_CCR;
        end else if (instr_boundary && irq && !s_q.condition_code_register[CCR_I_BIT]) begin
          s_d.vsel = {1'b0, top_source(pend)};
          s_d.snap = cpu_now;
          s_d.st = S_P_PCL;
        end
      end
      S_P_PCL: begin
        s_d.st = S_P_PCH;
      end
      S_P_PCH: begin
        s_d.st = S_P_X;
      end
      S_P_X: begin
        s_d.st = S_P_A;
      end
      S_P_A: begin
        s_d.st = S_P_CCR;
      end
      S_P_CCR: begin
        s_d.condition_code_register[CCR_I_BIT] = 1'b1;
        // a source that rose during stacking may outrank the accepted one
        if (s_q.vsel != SWI_SEL && irq) begin
          s_d.vsel = {1'b0, top_source(pend)};
        end
        s_d.st = S_V_HI;
      end
      S_V_HI: begin
        s_d.st = S_V_LO;
      end
      S_V_LO: begin
        s_d.vhi = mem_rdata;
        s_d.st = S_V_WAIT;
      end
      S_V_WAIT: begin
        s_d.target = {s_q.vhi, mem_rdata};
        s_d.st = S_Q0;
      end
      S_Q0: begin
        s_d.st = S_Q1;
      end
      S_Q1, S_Q2, S_Q_END: begin
        s_d.queue_byte = mem_rdata;
        s_d.queue_valid = 1'b1;
        s_d.st = (s_q.st == S_Q1) ? S_Q2 : (s_q.st == S_Q2) ? S_Q_END : S_IDLE;
        if (s_q.st == S_Q_END) begin
          s_d.frame_load = 1'b1;
          s_d.frame_out = '{s_q.target, s_q.snap.x, s_q.snap.a,
                            s_q.snap.sp - FRAME_BYTES};
        end
      end
      S_U_CCR: begin
        s_d.st = S_U_A;
      end
      S_U_A: begin
        s_d.condition_code_register = mem_rdata;
        s_d.st = S_U_X;
      end
      S_U_X: begin
        s_d.snap.a = mem_rdata;
        s_d.st = S_U_PCH;
      end
      S_U_PCH: begin
        s_d.snap.x = mem_rdata;
        s_d.st = S_U_PCL;
      end
      S_U_PCL: begin
        s_d.snap.pc[15:8] = mem_rdata;
        s_d.st = S_U_END;
      end
      S_U_END: begin
        s_d.frame_load = 1'b1;
        s_d.frame_out = '{{s_q.snap.pc[15:8], mem_rdata}, s_q.snap.x, s_q.snap.a,
                          s_q.snap.sp + FRAME_BYTES};
        s_d.st = S_IDLE;
      end
      default: begin
        s_d.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
      s_q.st <= S_IDLE;
      s_q.condition_code_register <= CCR_RESET;
      s_q.enable <= ENABLE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  flag_set_a: assert property (@(posedge clk) disable iff (reset)
    periph_event[0] |=> s_q.flags[1])
    else $error("peripheral event did not set its flag");

  accept_masked_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.st == S_IDLE && !swi_exec && !debug_swi && !rti_exec && s_q.condition_code_register[CCR_I_BIT])
    |=> s_q.st == S_IDLE)
    else $error("request accepted while mask set");

  reset_mask_a: assert property (@(posedge clk)
    $past(reset) && !reset |-> s_q.condition_code_register[CCR_I_BIT] && !busy)
    else $error("mask bit clear after reset");

  wait_boundary_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.st == S_IDLE && !instr_boundary && !swi_exec && !debug_swi && !rti_exec)
    |=> s_q.st == S_IDLE)
    else $error("response started inside an instruction");

  push_order_a: assert property (@(posedge clk) disable iff (reset)
    s_q.st == S_P_PCL |-> mem_req.we && mem_req.wdata == s_q.snap.pc[7:0]
    ##1 mem_req.wdata == s_q.snap.pc[15:8] ##1 mem_req.wdata == s_q.snap.x
    ##1 mem_req.wdata == s_q.snap.a ##1 mem_req.wdata == s_q.condition_code_register && mem_req.we)
    else $error("stacking order wrong");

  mask_after_a: assert property (@(posedge clk) disable iff (reset)
    s_q.st == S_P_CCR |=> s_q.condition_code_register[CCR_I_BIT] && s_q.st == S_V_HI)
    else $error("mask not set after stacking");

  vector_pick_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.st == S_P_CCR && s_q.vsel != SWI_SEL && irq)
    |=> !s_q.vsel[3] && ($past(pend) >> s_q.vsel[2:0]) == 8'h01)
    else $error("vector not of highest pending source");

  queue_three_a: assert property (@(posedge clk) disable iff (reset)
    s_q.st == S_Q0 |-> ##2 queue_valid [*3] ##1 !queue_valid)
    else $error("instruction queue not filled with three bytes");

  sp_frame_a: assert property (@(posedge clk) disable iff (reset)
    s_q.st == S_P_PCL |-> ##12 frame_load && frame_out.sp == $past(s_q.snap.sp, 12) - 16'h0005)
    else $error("stack pointer not one below saved ccr");

  rti_done_a: assert property (@(posedge clk) disable iff (reset)
    s_q.st == S_U_CCR |-> ##6 frame_load && frame_out.sp == $past(s_q.snap.sp, 6) + 16'h0005)
    else $error("return did not reload frame in time");

  vec_bytes_a: assert property (@(posedge clk) disable iff (reset)
    s_q.st == S_V_HI |-> mem_req.re ##1 mem_req.addr == $past(mem_req.addr) + 16'h0001)
    else $error("vector byte order wrong");

  pin_edge_a: assert property (@(posedge clk) disable iff (reset)
    irq_pin && !s_q.pin_q |=> s_q.flags[PIN_FLAG_BIT])
    else $error("pin edge did not set pin flag");

  level_hold_a: assert property (@(posedge clk) disable iff (reset)
    s_q.lvl_sel && irq_pin && s_q.flags[PIN_FLAG_BIT] |=> s_q.flags[PIN_FLAG_BIT])
    else $error("pin flag cleared while pin asserted");

  debug_swi_a: assert property (@(posedge clk) disable iff (reset)
    s_q.st == S_IDLE && debug_swi |=> s_q.st == S_P_PCL && s_q.vsel == SWI_SEL)
    else $error("debug request did not start software interrupt");

  stacked_pc_a: assert property (@(posedge clk) disable iff (reset)
    s_q.st == S_IDLE && instr_boundary && irq && !s_q.condition_code_register[CCR_I_BIT] && !swi_exec
    && !debug_swi && !rti_exec |=> s_q.st == S_P_PCL && s_q.snap.pc == $past(cpu_now.pc))
    else $error("stacked pc is not the next instruction");

  edge_clear_a: assert property (@(posedge clk) disable iff (reset)
    !s_q.lvl_sel && reg_we && reg_addr == ADDR_STATUS && reg_wdata[PIN_FLAG_BIT]
    && !(irq_pin && !s_q.pin_q) |=> !s_q.flags[PIN_FLAG_BIT])
    else $error("pin flag not cleared in edge-only mode");

  hw_entry_c: cover property (@(posedge clk) disable iff (reset)
    s_q.st == S_IDLE && instr_boundary && irq && !s_q.condition_code_register[CCR_I_BIT] && !swi_exec);
  rti_c: cover property (@(posedge clk) disable iff (reset) s_q.st == S_U_END);
  level_hold_c: cover property (@(posedge clk) disable iff (reset)
    reg_we && reg_addr == ADDR_STATUS && reg_wdata[0] && s_q.lvl_sel && irq_pin);
  debug_entry_c: cover property (@(posedge clk) disable iff (reset)
    s_q.st == S_IDLE && debug_swi);

endmodule // cpu_interrupt_sequencer

`default_nettype wire

/* rtl/cpu_irq_pkg.sv */
// Purpose: shared constants and types of the cpu interrupt sequencer
// Assumes: 8-bit core, 16-bit address space, single clock domain
// Notes: register offsets index the plain register port

package cpu_irq_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS = 4'h0; // sticky flags, write one to clear
  localparam logic [3:0] ADDR_ENABLE = 4'h1; // local enables
  localparam logic [3:0] ADDR_CTRL = 4'h2; // bit 0 pin_edge_level_select
  localparam logic [3:0] ADDR_CCR = 4'h3; // condition_code_register
  localparam logic [3:0] ADDR_SEQ = 4'h4; // read-only sequencer state

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int CCR_I_BIT = 3;
  localparam logic [7:0] CCR_RESET = 8'h08; // only the global mask set
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam int CTRL_LVL_BIT = 0;
  localparam int PIN_FLAG_BIT = 0; // pin_interrupt_flag sits in bit 0

  // ----------------------------------------------------------------
  // vectors and stack frame
  // ----------------------------------------------------------------
  localparam logic [3:0] SWI_SEL = 4'h8; // selector for the software vector
  localparam logic [15:0] VEC_SWI_ADDR = 16'hfffc;
  localparam logic [15:0] VEC_SRC_TOP = 16'hfffa; // source k at top - 2k
  localparam logic [15:0] FRAME_BYTES = 16'h0005;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    S_IDLE = 5'h00,
    S_P_PCL = 5'h01,
    S_P_PCH = 5'h03,
    S_P_X = 5'h02,
    S_P_A = 5'h06,
    S_P_CCR = 5'h07,
    S_V_HI = 5'h05,
    S_V_LO = 5'h04,
    S_V_WAIT = 5'h0c,
    S_Q0 = 5'h0d,
    S_Q1 = 5'h0f,
    S_Q2 = 5'h0e,
    S_Q_END = 5'h0a,
    S_U_CCR = 5'h18,
    S_U_A = 5'h19,
    S_U_X = 5'h1b,
    S_U_PCH = 5'h1a,
    S_U_PCL = 5'h1e,
    S_U_END = 5'h1f
  } seq_state_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] x;
    logic [7:0] a;
    logic [15:0] sp;
  } cpu_frame_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } mem_req_t;

  typedef struct packed {
    seq_state_t st;
    logic [7:0] condition_code_register;
    logic [7:0] flags;
    logic [7:0] enable;
    logic lvl_sel;
    logic pin_q;
    cpu_frame_t snap;
    logic [3:0] vsel;
    logic [7:0] vhi;
    logic [15:0] target;
    logic [7:0] rdata;
    logic queue_valid;
    logic [7:0] queue_byte;
    logic frame_load;
    cpu_frame_t frame_out;
  } seq_regs_t;

endpackage
